// ### hdl/hsw_ctrl.v
// Functional notes
// RULE1 - overvoltage turns outputs off unless disabled
// RULE2 - undervoltage turns outputs off unless disabled
// RULE3 - recovery bit restores, else configs cleared
// RULE4 - supply faults only in supply flags
// RULE5 - filtered overcurrent turns output off, flags
// RULE6 - overcurrent trip resets config to 000
// RULE7 - software restarts by writing on/timer code
// RULE8 - overcurrent flags sticky until software clears
// RULE9 - open load flags, output stays on
// RULE10 - open load flag sticky, clear once gone
// RULE11 - config writable only in normal mode
// RULE12 - restart or fail-safe switches outputs off
// RULE13 - protections and PWM active in stop/sleep
// RULE14 - two PWM generators, 8-bit duty each
// RULE15 - each generator 200 or 400 Hz
// RULE16 - config selects off/on/timers/PWMs
// RULE17 - PWM starts at once on assignment
// RULE18 - duty 1 gives no real pulse
// RULE19 - duty minimum for open load detection
// RULE20 - duty minimum for overcurrent detection
// RULE21 - open load confirmed after 64 us filter
// RULE22 - 256 steps, on for duty steps
`timescale 1ns/1ps
`include "hsw_map.vh"
module hsw_ctrl (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] power_mode,
  input wire timer_a_in,
  input wire timer_b_in,
  input wire switch_supply_ov_in,
  input wire switch_supply_uv_in,
  input wire [3:0] overcurrent_in,
  input wire [3:0] open_load_in,
  output reg [3:0] switched_output
);
  localparam integer OC_CYC_N = `HSW_OC_CYC;
  localparam integer OL_CYC_N = `HSW_OL_CYC;
  localparam [11:0] OC_CYC = OC_CYC_N[11:0];
  localparam [11:0] OL_CYC = OL_CYC_N[11:0];

  // ==========================================================
  // source select per output
  function sel_src;
    input [2:0] code;
    input t_a;
    input t_b;
    input p_a;
    input p_b;
    begin
      case (code)
        `HSW_CFG_ON: sel_src = 1'b1;
        `HSW_CFG_TMR_A: sel_src = t_a;
        `HSW_CFG_TMR_B: sel_src = t_b;
        `HSW_CFG_PWM_A: sel_src = p_a;
        `HSW_CFG_PWM_B: sel_src = p_b;
        default: sel_src = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // register state
  reg [11:0] output_config;
  reg [7:0] pwm_duty_a;
  reg [7:0] pwm_duty_b;
  reg [1:0] pwm_frequency_select;
  reg [2:0] supply_ctrl;
  reg [3:0] overcurrent_status;
  reg [3:0] open_load_status;
  reg [11:0] oc_cnt [0:3];
  reg [11:0] ol_cnt [0:3];
  reg [1:0] sync_ov;
  reg [1:0] sync_uv;
  reg [3:0] sync_oc_a;
  reg [3:0] sync_oc_b;
  reg [3:0] sync_ol_a;
  reg [3:0] sync_ol_b;
  reg fault_q;
  reg mode_off_q;
  reg aw_full;
  reg w_full;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [3:0] oc_trip;
  reg [3:0] ol_hit;
  reg [3:0] next_drive;
  reg [31:0] next_rdata;
  reg next_rerr;
  wire pwm_a;
  wire pwm_b;
  wire switch_supply_overvoltage_flag;
  wire switch_supply_undervoltage_flag;
  wire supply_fault;
  wire fault_end;
  wire mode_normal;
  wire mode_off;
  wire mode_off_entry;
  wire wr_go;
  wire wr_lane0;
  integer i;
  integer j;
  integer k;

  // ==========================================================
  // input synchronisers
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_ov <= 2'h0;
      sync_uv <= 2'h0;
      sync_oc_a <= 4'h0;
      sync_oc_b <= 4'h0;
      sync_ol_a <= 4'h0;
      sync_ol_b <= 4'h0;
    end else begin
      sync_ov <= {sync_ov[0], switch_supply_ov_in};
      sync_uv <= {sync_uv[0], switch_supply_uv_in};
      sync_oc_a <= overcurrent_in;
      sync_oc_b <= sync_oc_a;
      sync_ol_a <= open_load_in;
      sync_ol_b <= sync_ol_a;
    end
  end

  assign switch_supply_overvoltage_flag = sync_ov[1]; // RULE4
  assign switch_supply_undervoltage_flag = sync_uv[1]; // RULE4

  // ==========================================================
  // supply fault and power mode
  assign supply_fault = (switch_supply_overvoltage_flag & ~supply_ctrl[`HSW_SC_OV_DIS]) | // RULE1
    (switch_supply_undervoltage_flag & ~supply_ctrl[`HSW_SC_UV_DIS]); // RULE2
  assign fault_end = fault_q & ~supply_fault;
  assign mode_normal = (power_mode == `HSW_MODE_NORMAL);
  assign mode_off = (power_mode == `HSW_MODE_RESTART) || (power_mode == `HSW_MODE_FAILSAFE);
  assign mode_off_entry = mode_off & ~mode_off_q;

  // ==========================================================
  // pwm generators
  hsw_pwm u_pwm_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .freq_hi(pwm_frequency_select[0]),
    .duty(pwm_duty_a),
    .pwm_out(pwm_a)
  ); // RULE14
  hsw_pwm u_pwm_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .freq_hi(pwm_frequency_select[1]),
    .duty(pwm_duty_b),
    .pwm_out(pwm_b)
  ); // RULE14

  // ==========================================================
  // output drive and filter terms
  always @* begin
    next_drive = 4'h0;
    oc_trip = 4'h0;
    ol_hit = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      next_drive[i] = sel_src(output_config[3*i +: 3], timer_a_in, timer_b_in,
        pwm_a, pwm_b) & ~supply_fault & ~mode_off; // RULE16 RULE17 RULE13 RULE12
      oc_trip[i] = (oc_cnt[i] >= OC_CYC); // RULE5
      ol_hit[i] = (ol_cnt[i] >= OL_CYC); // RULE21
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      switched_output <= 4'h0;
      fault_q <= 1'b0;
      mode_off_q <= 1'b0;
      for (j = 0; j < 4; j = j + 1) begin
        oc_cnt[j] <= 12'h000;
        ol_cnt[j] <= 12'h000;
      end
    end else begin
      switched_output <= next_drive & ~oc_trip; // RULE5
      fault_q <= supply_fault;
      mode_off_q <= mode_off;
      for (j = 0; j < 4; j = j + 1) begin
        if (switched_output[j] && sync_oc_b[j] && !oc_trip[j])
          oc_cnt[j] <= oc_cnt[j] + 12'h001; // RULE5
        else if (!switched_output[j] || !sync_oc_b[j])
          oc_cnt[j] <= 12'h000;
        if (switched_output[j] && sync_ol_b[j]) begin
          if (!ol_hit[j])
            ol_cnt[j] <= ol_cnt[j] + 12'h001; // RULE21
        end else if (!sync_ol_b[j]) begin
          ol_cnt[j] <= 12'h000;
        end
      end
    end
  end

  // ==========================================================
  // axi4-lite write channel
  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full & ~s_axi_bvalid;
  assign wr_go = aw_full & w_full & ~s_axi_bvalid;
  assign wr_lane0 = wr_go & w_strb[0];

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `HSW_ADDR_OUT_STAT || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // register writes and hardware updates
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      output_config <= `HSW_RST_CFG;
      pwm_duty_a <= `HSW_RST_DUTY;
      pwm_duty_b <= `HSW_RST_DUTY;
      pwm_frequency_select <= `HSW_RST_FREQ;
      supply_ctrl <= `HSW_RST_SC;
      overcurrent_status <= 4'h0;
      open_load_status <= 4'h0;
    end else begin
      if (wr_lane0 && mode_normal && aw_addr == `HSW_ADDR_CFG_A)
        output_config[5:0] <= w_data[5:0]; // RULE11
      if (wr_lane0 && mode_normal && aw_addr == `HSW_ADDR_CFG_B)
        output_config[11:6] <= w_data[5:0]; // RULE11
      if (wr_lane0 && aw_addr == `HSW_ADDR_DUTY_A)
        pwm_duty_a <= w_data[7:0];
      if (wr_lane0 && aw_addr == `HSW_ADDR_DUTY_B)
        pwm_duty_b <= w_data[7:0];
      if (wr_lane0 && aw_addr == `HSW_ADDR_FREQ)
        pwm_frequency_select <= w_data[1:0]; // RULE15
      if (wr_lane0 && aw_addr == `HSW_ADDR_SUPPLY_CTRL)
        supply_ctrl <= w_data[2:0];
      if (fault_end && !supply_ctrl[`HSW_SC_REC])
        output_config <= `HSW_RST_CFG; // RULE3
      if (mode_off_entry)
        output_config <= `HSW_RST_CFG; // RULE12
      for (k = 0; k < 4; k = k + 1)
        if (oc_trip[k])
          output_config[3*k +: 3] <= `HSW_CFG_OFF; // RULE6
      // clear by writing one, hardware set wins
      overcurrent_status <= (overcurrent_status &
        ~((wr_lane0 && aw_addr == `HSW_ADDR_OC_STAT) ? w_data[3:0] : 4'h0)) | oc_trip; // RULE8
      open_load_status <= (open_load_status &
        ~((wr_lane0 && aw_addr == `HSW_ADDR_OL_STAT) ? w_data[3:0] : 4'h0)) | ol_hit; // RULE9 RULE10
    end
  end

  // ==========================================================
  // axi4-lite read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    case (s_axi_araddr)
      `HSW_ADDR_CFG_A: next_rdata[5:0] = output_config[5:0];
      `HSW_ADDR_CFG_B: next_rdata[5:0] = output_config[11:6];
      `HSW_ADDR_DUTY_A: next_rdata[7:0] = pwm_duty_a;
      `HSW_ADDR_DUTY_B: next_rdata[7:0] = pwm_duty_b;
      `HSW_ADDR_FREQ: next_rdata[1:0] = pwm_frequency_select;
      `HSW_ADDR_SUPPLY_CTRL: next_rdata[2:0] = supply_ctrl;
      `HSW_ADDR_SUPPLY_STAT: next_rdata[1:0] = {switch_supply_undervoltage_flag,
        switch_supply_overvoltage_flag}; // RULE4
      `HSW_ADDR_OC_STAT: next_rdata[3:0] = overcurrent_status;
      `HSW_ADDR_OL_STAT: next_rdata[3:0] = open_load_status;
      `HSW_ADDR_OUT_STAT: next_rdata[3:0] = switched_output;
      default: next_rerr = 1'b1;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? 2'h2 : 2'h0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // hsw_ctrl

// ### hdl/hsw_map.vh
`ifndef HSW_MAP_VH
`define HSW_MAP_VH
// ==========================================================
// register offsets (byte addresses)
`define HSW_ADDR_CFG_A 8'h00
`define HSW_ADDR_CFG_B 8'h04
`define HSW_ADDR_DUTY_A 8'h08
`define HSW_ADDR_DUTY_B 8'h0c
`define HSW_ADDR_FREQ 8'h10
`define HSW_ADDR_SUPPLY_CTRL 8'h14
`define HSW_ADDR_SUPPLY_STAT 8'h18
`define HSW_ADDR_OC_STAT 8'h1c
`define HSW_ADDR_OL_STAT 8'h20
`define HSW_ADDR_OUT_STAT 8'h24
// ==========================================================
// field positions and codes
`define HSW_SC_OV_DIS 0
`define HSW_SC_UV_DIS 1
`define HSW_SC_REC 2
`define HSW_CFG_OFF 3'h0
`define HSW_CFG_ON 3'h1
`define HSW_CFG_TMR_A 3'h2
`define HSW_CFG_TMR_B 3'h3
`define HSW_CFG_PWM_A 3'h4
`define HSW_CFG_PWM_B 3'h5
`define HSW_MODE_NORMAL 3'h0
`define HSW_MODE_STOP 3'h1
`define HSW_MODE_SLEEP 3'h2
`define HSW_MODE_RESTART 3'h3
`define HSW_MODE_FAILSAFE 3'h4
// ==========================================================
// reset values
`define HSW_RST_CFG 12'h000
`define HSW_RST_DUTY 8'h00
`define HSW_RST_FREQ 2'h0
`define HSW_RST_SC 3'h0
// ==========================================================
// timing
`define HSW_CLK_HZ 50000000
`define HSW_CLK_MHZ 50
`define HSW_OC_FILT_US 16
`define HSW_OL_FILT_US 64
`define HSW_OC_CYC (`HSW_OC_FILT_US * `HSW_CLK_MHZ)
`define HSW_OL_CYC (`HSW_OL_FILT_US * `HSW_CLK_MHZ)
`define HSW_PWM_LO_HZ 200
`define HSW_PWM_HI_HZ 400
`define HSW_PWM_STEPS 256
`define HSW_STEP_LO_CYC (`HSW_CLK_HZ / (`HSW_PWM_LO_HZ * `HSW_PWM_STEPS))
`define HSW_STEP_HI_CYC (`HSW_CLK_HZ / (`HSW_PWM_HI_HZ * `HSW_PWM_STEPS))
`endif

// ### hdl/hsw_pwm.v
`timescale 1ns/1ps
`include "hsw_map.vh"
module hsw_pwm (
  input wire clk_sys,
  input wire rst_n,
  input wire freq_hi,
  input wire [7:0] duty,
  output reg pwm_out
);
  localparam integer STEP_LO_N = `HSW_STEP_LO_CYC;
  localparam integer STEP_HI_N = `HSW_STEP_HI_CYC;
  localparam [9:0] STEP_LO = STEP_LO_N[9:0];
  localparam [9:0] STEP_HI = STEP_HI_N[9:0];
  reg [9:0] presc;
  reg [7:0] step;
  wire [9:0] step_last;
  wire step_tick;

  // ==========================================================
  // step divider, 256 steps per period
  assign step_last = freq_hi ? (STEP_HI - 10'h001) : (STEP_LO - 10'h001); // RULE15
  assign step_tick = (presc >= step_last);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      presc <= 10'h000;
      step <= 8'h00;
      pwm_out <= 1'b0;
    end else begin
      if (step_tick) begin
        presc <= 10'h000;
        step <= step + 8'h01; // RULE22
      end else begin
        presc <= presc + 10'h001;
      end
      pwm_out <= (step < duty); // RULE22
    end
  end
endmodule // hsw_pwm

// ### test/hsw_load.sv
`timescale 1ns/1ps
module hsw_load (
  input wire [3:0] switched_output,
  input wire [3:0] short_mask,
  input wire [3:0] open_mask,
  output wire [3:0] overcurrent_in,
  output wire [3:0] open_load_in
);
  // ==========
  // load current only flows while switched on
  assign overcurrent_in = switched_output & short_mask;
  assign open_load_in = switched_output & open_mask;
endmodule // hsw_load

// ### test/hsw_checker.sv
`timescale 1ns/1ps
module hsw_checker (
  input wire clk_sys,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] power_mode,
  input wire [3:0] overcurrent_in,
  input wire [3:0] switched_output
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========
  // cycles output 0 stays on into overcurrent
  reg [10:0] oc_run;
  always @(posedge clk_sys) begin
    if (!rst_n || !(overcurrent_in[0] && switched_output[0]))
      oc_run <= 11'h000;
    else if (oc_run != 11'h7ff)
      oc_run <= oc_run + 11'h001;
  end
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence fault_mode;
    (power_mode == 3'h3 || power_mode == 3'h4) [*2];
  endsequence
  // ==========
  // properties
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_wr_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("no read response");
  chk_restart_off: assert property (fault_mode |-> switched_output == 4'h0)
    else $error("output on in restart");
  chk_oc_filter: assert property (oc_run <= 11'h32a)
    else $error("overcurrent not tripped");
endmodule // hsw_checker

// ### test/test_high_side_switch_pwm_ctrl.sv
`timescale 1ns/1ps
`include "hsw_map.vh"
module test_high_side_switch_pwm_ctrl;
  reg clk_sys = 1'b0, rst_n = 1'b0, timer_a = 1'b1, timer_b = 1'b0, ov = 1'b0, uv = 1'b0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0, d;
  reg [2:0] power_mode = 3'h0;
  reg [3:0] short_mask = 4'h0, open_mask = 4'h0;
  reg [1:0] r;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] oc, ol, sw;
  integer fail_count = 0, tests_run = 0, cyc_n = 0, c, m;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc_n <= rst_n ? cyc_n + 1 : 0;
  hsw_ctrl i_hsw_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .power_mode(power_mode), .timer_a_in(timer_a), .timer_b_in(timer_b),
    .switch_supply_ov_in(ov), .switch_supply_uv_in(uv), .overcurrent_in(oc),
    .open_load_in(ol), .switched_output(sw));
  hsw_load i_hsw_load (.switched_output(sw), .short_mask(short_mask),
    .open_mask(open_mask), .overcurrent_in(oc), .open_load_in(ol));
  // ==========
  // bus and check tasks
  task test_done;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(input [7:0] a, input [31:0] v);
    integer k;
    reg done;
    begin
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      for (k = 0; k < 50 && !done; k = k + 1) begin
        @(posedge clk_sys);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          bready <= 1'b0;
          r = bresp;
          done = 1'b1;
        end
      end
      if (!done) begin
        chk("write timeout", 1, done);
        test_done;
      end
      @(posedge clk_sys);
    end
  endtask
  task rc(input string nm, input [7:0] a, input [31:0] e);
    integer k;
    reg done;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      for (k = 0; k < 50 && !done; k = k + 1) begin
        @(posedge clk_sys);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          rready <= 1'b0;
          d = rdata;
          r = rresp;
          done = 1'b1;
        end
      end
      if (!done) begin
        chk("read timeout", 1, done);
        test_done;
      end
      chk(nm, e, d);
      @(posedge clk_sys);
    end
  endtask
  task until_off(input integer b, input integer lim);
    begin
      c = 0;
      while (sw[b] !== 1'b0 && c < lim) begin
        @(posedge clk_sys);
        c = c + 1;
      end
      if (sw[b] !== 1'b0) begin
        chk("until off", 0, sw[b]);
        test_done;
      end
    end
  endtask
  // ==========
  // scenarios
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (m = 0; m < 10; m = m + 1) rc("reset value", m * 4, 0);
    rc("unmapped", 8'h30, 0);
    chk("unmapped resp", 2'b10, r);
    wr(8'h30, 0);
    chk("unmapped wr resp", 2'b10, r);
    wr(`HSW_ADDR_DUTY_A, 3);
    chk("wr resp", 2'b00, r);
    wr(`HSW_ADDR_DUTY_B, 2);
    wr(`HSW_ADDR_FREQ, 1);
    wr(`HSW_ADDR_CFG_B, {`HSW_CFG_TMR_B, `HSW_CFG_TMR_A});
    wr(`HSW_ADDR_CFG_A, {`HSW_CFG_PWM_B, `HSW_CFG_PWM_A});
    cyc(3);
    chk("pwm start", 4'h7, sw);
    timer_a <= 1'b0;
    timer_b <= 1'b1;
    cyc(3);
    chk("timers", 4'hb, sw);
    until_off(0, 1600);
    chk("pwm a high", 1, cyc_n > 1459 && cyc_n < 1471);
    until_off(1, 600);
    chk("pwm b high", 1, cyc_n > 1947 && cyc_n < 1959);
    wr(`HSW_ADDR_CFG_B, 0);
    wr(`HSW_ADDR_CFG_A, `HSW_CFG_ON);
    cyc(3);
    chk("on off", 4'h1, sw);
    short_mask <= 4'h1;
    until_off(0, 900);
    chk("oc filter", 1, c > 794 && c < 811);
    rc("oc flag", `HSW_ADDR_OC_STAT, 1);
    rc("oc cfg", `HSW_ADDR_CFG_A, 0);
    short_mask <= 4'h0;
    cyc(5);
    rc("oc sticky", `HSW_ADDR_OC_STAT, 1);
    wr(`HSW_ADDR_OC_STAT, 1);
    rc("oc clear", `HSW_ADDR_OC_STAT, 0);
    wr(`HSW_ADDR_CFG_A, `HSW_CFG_ON);
    open_mask <= 4'h1;
    cyc(3150);
    rc("ol early", `HSW_ADDR_OL_STAT, 0);
    cyc(150);
    rc("ol flag", `HSW_ADDR_OL_STAT, 1);
    chk("ol on", 4'h1, sw);
    wr(`HSW_ADDR_OL_STAT, 1);
    rc("ol held", `HSW_ADDR_OL_STAT, 1);
    open_mask <= 4'h0;
    cyc(5);
    wr(`HSW_ADDR_OL_STAT, 1);
    rc("ol clear", `HSW_ADDR_OL_STAT, 0);
    ov <= 1'b1;
    cyc(5);
    chk("ov off", 4'h0, sw);
    rc("ov flag", `HSW_ADDR_SUPPLY_STAT, 1);
    rc("ov no oc", `HSW_ADDR_OC_STAT, 0);
    ov <= 1'b0;
    cyc(5);
    chk("no recovery", 4'h0, sw);
    rc("cfg cleared", `HSW_ADDR_CFG_A, 0);
    wr(`HSW_ADDR_SUPPLY_CTRL, 4);
    wr(`HSW_ADDR_CFG_A, `HSW_CFG_ON);
    uv <= 1'b1;
    cyc(5);
    chk("uv off", 4'h0, sw);
    rc("uv flag", `HSW_ADDR_SUPPLY_STAT, 2);
    uv <= 1'b0;
    cyc(5);
    chk("recovery", 4'h1, sw);
    wr(`HSW_ADDR_SUPPLY_CTRL, 7);
    ov <= 1'b1;
    uv <= 1'b1;
    cyc(5);
    chk("shutdown disabled", 4'h1, sw);
    ov <= 1'b0;
    uv <= 1'b0;
    power_mode <= `HSW_MODE_STOP;
    wr(`HSW_ADDR_CFG_A, 0);
    rc("cfg locked", `HSW_ADDR_CFG_A, 1);
    chk("stop on", 4'h1, sw);
    power_mode <= `HSW_MODE_SLEEP;
    wr(`HSW_ADDR_CFG_A, 0);
    rc("sleep locked", `HSW_ADDR_CFG_A, 1);
    chk("sleep on", 4'h1, sw);
    for (m = 3; m < 5; m = m + 1) begin
      power_mode <= m;
      cyc(3);
      chk("restart off", 4'h0, sw);
      power_mode <= `HSW_MODE_NORMAL;
      wr(`HSW_ADDR_CFG_A, `HSW_CFG_ON);
      cyc(3);
      chk("re-enable", 4'h1, sw);
    end
    test_done;
  end
endmodule // test_high_side_switch_pwm_ctrl
bind hsw_ctrl hsw_checker i_hsw_checker (.clk_sys(clk_sys), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .power_mode(power_mode), .overcurrent_in(overcurrent_in), .switched_output(switched_output));
